//--- logic/tec_pkg.sv
`default_nettype none
package tec_pkg;
	localparam int unsigned SYS_CLK_HZ     = 20000000;
	localparam logic [7:0]  COUNT_RESET    = 8'h00;
	localparam logic [7:0]  COUNT_MAX      = 8'hFF;
	localparam logic [7:0]  PRESC_RESET    = 8'h00;
	localparam logic [1:0]  TAP4_MASK_ONES = 2'h3;
	localparam logic [4:0]  TAP32_ONES     = 5'h1F;
	localparam logic [7:0]  TAP256_ONES    = 8'hFF;
	localparam logic [3:0]  MODE_PORT_SEL  = 4'hF;
	localparam int unsigned SEL_UPPER_POS  = 2;
	localparam int unsigned SEL_LOWER_POS  = 1;
	localparam int unsigned SEL_SPARE_POS  = 0;
	localparam int unsigned SYNC_STAGES    = 3;
	typedef enum logic [1:0] {
		TEC_SRC_DIV256 = 2'b00,
		TEC_SRC_EVENT  = 2'b01,
		TEC_SRC_DIV32  = 2'b10,
		TEC_SRC_DIV4   = 2'b11
	} tec_src_t;
	localparam tec_src_t    SRC_RESET      = TEC_SRC_DIV256;
endpackage
`default_nettype wire

//--- logic/tec_timer.sv
`timescale 1ns/1ns
`default_nettype none
module tec_timer (
	input  wire logic                sys_clk,
	input  wire logic                rstn,
	input  wire logic                timer_start,
	input  wire logic                read_count,
	output logic [7:0]               count_value,
	input  wire logic                skip_test,
	output logic                     skip_hit,
	input  wire logic                port_out_strobe,
	input  wire logic [3:0]          port_sel,
	input  wire logic [3:0]          port_data,
	input  wire logic                event_input,
	input  wire logic                other_request_flag,
	input  wire logic                halt_request,
	input  wire logic                stop_request,
	output logic                     halt_active,
	output logic                     stop_active,
	output logic                     overflow_signal,
	output logic                     overflow_request_flag,
	output tec_pkg::tec_src_t        source_select
);
	import tec_pkg::*;

	typedef struct packed {
		logic [7:0] presc;
		logic [7:0] cnt;
		tec_src_t   mode;
		logic       ev_s1;
		logic       ev_s2;
		logic       ev_s3;
		logic       ev_lvl;
		logic       pend;
		logic       ovf_flag;
		logic       ovf_pulse;
		logic [7:0] rd_data;
		logic       skip_hit;
		logic       halt;
		logic       stop;
	} tec_state_t;

	tec_state_t q;
	tec_state_t d;
	logic       rst_meta_q;
	logic       rst_sync_n_q;
	logic       tap4;
	logic       tap32;
	logic       tap256;
	logic       ev_rise;
	logic       cp;
	logic       inc;
	logic       ovf_set;
	logic       any_flag;
	logic       mode_wr;

	// reset enters asynchronously, leaves through two flops
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q   <= 1'b0;
			rst_sync_n_q <= 1'b0;
		end else begin
			rst_meta_q   <= 1'b1;
			rst_sync_n_q <= rst_meta_q;
		end
	end

	function automatic logic src_pulse(input tec_src_t m, input logic t4, input logic t32,
		input logic t256, input logic ev);
		unique case (m)
			TEC_SRC_DIV4:   src_pulse = t4;
			TEC_SRC_DIV32:  src_pulse = t32;
			TEC_SRC_DIV256: src_pulse = t256;
			TEC_SRC_EVENT:  src_pulse = ev;
		endcase
	endfunction

	always_comb begin
		// one free-running chain: /4 tap, then /8 stages give /32 and /256
		tap4     = (q.presc[1:0] == TAP4_MASK_ONES);
		tap32    = (q.presc[4:0] == TAP32_ONES);
		tap256   = (q.presc == TAP256_ONES);
		// stage two and three must agree before a level change counts
		ev_rise  = q.ev_s2 && q.ev_s3 && !q.ev_lvl;
		cp       = src_pulse(q.mode, tap4, tap32, tap256, ev_rise);
		inc      = (cp || q.pend) && !read_count && !timer_start;
		ovf_set  = inc && (q.cnt == COUNT_MAX);
		any_flag = q.ovf_flag || other_request_flag;
		mode_wr  = port_out_strobe && (port_sel == MODE_PORT_SEL);

		d           = q;
		d.presc     = q.presc + 8'h01;
		d.ev_s1     = event_input;
		d.ev_s2     = q.ev_s1;
		d.ev_s3     = q.ev_s2;
		if (q.ev_s2 == q.ev_s3) begin
			d.ev_lvl = q.ev_s3;
		end
		d.ovf_pulse = ovf_set;
		if (timer_start) begin
			d.cnt  = COUNT_RESET;
			d.pend = 1'b0;
		end else if (read_count) begin
			// a pulse landing mid-read is kept and applied after it
			d.pend = q.pend || cp;
		end else if (inc) begin
			d.cnt  = q.cnt + 8'h01;
			d.pend = 1'b0;
		end
		if (read_count) begin
			d.rd_data = q.cnt;
		end
		if (skip_test) begin
			d.skip_hit = q.ovf_flag;
		end
		// a new overflow in the clearing cycle is never lost
		d.ovf_flag = ovf_set || (q.ovf_flag && !skip_test && !timer_start);
		if (mode_wr) begin
			// spare bit is expected zero from the writer and is not stored
			d.mode = tec_src_t'({port_data[SEL_UPPER_POS], port_data[SEL_LOWER_POS]});
		end
		if (any_flag) begin
			d.halt = 1'b0;
		end else if (halt_request) begin
			d.halt = 1'b1;
		end
		if (stop_request && !any_flag) begin
			d.stop = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			q.presc     <= PRESC_RESET;
			q.cnt       <= COUNT_RESET;
			q.mode      <= SRC_RESET;
			q.ev_s1     <= 1'b0;
			q.ev_s2     <= 1'b0;
			q.ev_s3     <= 1'b0;
			q.ev_lvl    <= 1'b0;
			q.pend      <= 1'b0;
			q.ovf_flag  <= 1'b0;
			q.ovf_pulse <= 1'b0;
			q.rd_data   <= COUNT_RESET;
			q.skip_hit  <= 1'b0;
			q.halt      <= 1'b0;
			q.stop      <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign count_value           = q.rd_data;
	assign skip_hit              = q.skip_hit;
	assign overflow_signal       = q.ovf_pulse;
	assign overflow_request_flag = q.ovf_flag;
	assign halt_active           = q.halt;
	assign stop_active           = q.stop;
	assign source_select         = q.mode;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_sync_n_q);

	chk_count_step: assert property (inc && !ovf_set |=> q.cnt == 8'($past(q.cnt) + 8'h01))
		else $error("count did not advance by one");
	chk_start_clear: assert property (timer_start |=> q.cnt == COUNT_RESET && !q.pend)
		else $error("start did not clear count");
	chk_wrap_flag: assert property (ovf_set |=> q.cnt == COUNT_RESET && overflow_signal
		&& overflow_request_flag)
		else $error("wrap did not signal overflow");
	chk_read_hold: assert property (read_count && !timer_start |=> $stable(q.cnt))
		else $error("count moved during read");
	chk_read_value: assert property (read_count |=> count_value == $past(q.cnt))
		else $error("read value mismatch");
	chk_pend_apply: assert property (read_count && cp && !timer_start ##1 !read_count && !timer_start
		|-> inc)
		else $error("held pulse was lost after read");
	chk_flag_clear: assert property ((skip_test || timer_start) && !ovf_set
		|=> !overflow_request_flag)
		else $error("flag not cleared");
	chk_skip_report: assert property (skip_test |=> skip_hit == $past(q.ovf_flag))
		else $error("skip result wrong");
	chk_halt_wake: assert property (any_flag |=> !halt_active)
		else $error("halt held with request pending");
	chk_mode_write: assert property (mode_wr |=> source_select
		== tec_src_t'($past(port_data[2:1])))
		else $error("mode write not taken");
	chk_event_count: assert property (q.mode == TEC_SRC_EVENT && ev_rise |-> cp)
		else $error("event edge gave no pulse");
	chk_div4_tap: assert property (q.mode == TEC_SRC_DIV4 |-> cp == tap4)
		else $error("divide by four tap wrong");

	// flag and pulse: one-cycle pulse, sticky flag until tested or started
	chk_pulse_single: assert property (overflow_signal
		|=> !overflow_signal)
		else $error("overflow pulse longer than one cycle");
	chk_pulse_cause: assert property (overflow_signal
		|-> $past(q.cnt) == COUNT_MAX)
		else $error("overflow pulse without a wrap");
	chk_ovf_only_wrap: assert property (!ovf_set
		|=> !overflow_signal)
		else $error("overflow pulse with no wrap");
	chk_flag_source: assert property ($rose(overflow_request_flag)
		|-> overflow_signal)
		else $error("flag rose without overflow");
	chk_flag_sticky: assert property (overflow_request_flag && !skip_test && !timer_start
		|=> overflow_request_flag)
		else $error("flag dropped untested");
	chk_flag_quiet: assert property (!ovf_set && !overflow_request_flag
		|=> !overflow_request_flag)
		else $error("flag set with no overflow");
	chk_start_flag: assert property (timer_start
		|=> !overflow_request_flag)
		else $error("start left the flag set");
	chk_skip_clear: assert property (skip_test && overflow_request_flag && !ovf_set
		|=> skip_hit && !overflow_request_flag)
		else $error("skip test did not take the flag");
	chk_skip_miss: assert property (skip_test && !overflow_request_flag
		|=> !skip_hit)
		else $error("skip hit with flag clear");
	chk_skip_keep: assert property (!skip_test
		|=> $stable(skip_hit))
		else $error("skip result moved without a test");

	// read path: frozen count, one pulse kept across a read
	chk_read_keep: assert property (!read_count
		|=> $stable(count_value))
		else $error("read value moved without a read");
	chk_read_pend: assert property (read_count && cp && !timer_start
		|=> q.pend)
		else $error("pulse during read was dropped");
	chk_pend_clear: assert property (inc
		|=> !q.pend)
		else $error("held pulse applied twice");
	chk_idle_hold: assert property (!inc && !timer_start
		|=> $stable(q.cnt))
		else $error("count moved without a pulse");
	chk_mode_keep: assert property (!mode_wr
		|=> $stable(source_select))
		else $error("select changed without a write");

	// all taps come from one counter, so they nest inside the /4 tick
	chk_tap4_period: assert property (tap4
		|=> !tap4 ##1 !tap4 ##1 !tap4 ##1 tap4)
		else $error("divide by four tap off period");
	chk_tap32_chain: assert property (tap32
		|-> tap4)
		else $error("divide by 32 tap off the chain");
	chk_tap256_chain: assert property (tap256
		|-> tap32)
		else $error("divide by 256 tap off the chain");
	chk_event_single: assert property (ev_rise
		|=> !ev_rise)
		else $error("one pin edge gave two pulses");
	chk_event_quiet: assert property (q.mode == TEC_SRC_EVENT && !ev_rise
		|-> !cp)
		else $error("event mode pulsed with no edge");

	// standby: entry refused while any flag is up, stop only leaves by reset
	chk_halt_refuse: assert property (halt_request && any_flag
		|=> !halt_active)
		else $error("halt entered with a flag set");
	chk_halt_enter: assert property (halt_request && !any_flag
		|=> halt_active)
		else $error("halt request ignored");
	chk_halt_hold: assert property (halt_active && !any_flag
		|=> halt_active)
		else $error("halt left with no flag");
	chk_stop_refuse: assert property (stop_request && any_flag && !stop_active
		|=> !stop_active)
		else $error("stop entered with a flag set");
	chk_stop_enter: assert property (stop_request && !any_flag
		|=> stop_active)
		else $error("stop request ignored");
	chk_stop_hold: assert property (stop_active
		|=> stop_active)
		else $error("stop left without reset");

	cov_overflow: cover property (ovf_set ##1 overflow_request_flag);
	cov_read_pend: cover property (read_count && cp ##1 !read_count);
	cov_halt_wake: cover property (halt_active ##1 !halt_active);
	cov_event_count: cover property (q.mode == TEC_SRC_EVENT && inc);
	cov_stop_entry: cover property (stop_request && !any_flag ##1 stop_active);
endmodule
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import tec_pkg::*;
	logic       sys_clk = 1'b0;
	logic       rstn = 1'b0;
	logic       event_input = 1'b0;
	logic       ts, rc, sk, po, hr, sr, orf, skip_hit, halt_active, stop_active, ovf, flag;
	logic [3:0] ps, pd;
	logic [7:0] count_value;
	tec_src_t   src;
	int         mismatches = 0;
	int         total_checks = 0;
	int         n;
	always #25 sys_clk = ~sys_clk;
	tec_cpu_model cpu (.sys_clk(sys_clk), .timer_start(ts), .read_count(rc), .skip_test(sk),
		.port_out_strobe(po), .port_sel(ps), .port_data(pd), .halt_request(hr),
		.stop_request(sr), .other_request_flag(orf));
	tec_timer dut (.sys_clk(sys_clk), .rstn(rstn), .timer_start(ts), .read_count(rc),
		.count_value(count_value), .skip_test(sk), .skip_hit(skip_hit),
		.port_out_strobe(po), .port_sel(ps), .port_data(pd), .event_input(event_input),
		.other_request_flag(orf), .halt_request(hr), .stop_request(sr),
		.halt_active(halt_active), .stop_active(stop_active), .overflow_signal(ovf),
		.overflow_request_flag(flag), .source_select(src));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// bounded wait for the overflow pulse, n counts the cycles spent after the first
	task automatic wait_ovf();
		n = 0;
		@(negedge sys_clk);
		while (ovf !== 1'b1 && n < 70000) begin
			@(negedge sys_clk);
			n++;
		end
	endtask
	task automatic s_div4();
		check("src reset", 16'(src), 16'(SRC_RESET));
		cpu.op(3, 4'h3, 2'b11);
		check("src other port", 16'(src), 16'(SRC_RESET));
		cpu.op(3, MODE_PORT_SEL, 2'b11);
		check("src div4", 16'(src), 16'(TEC_SRC_DIV4));
		cpu.op(0, 4'h0, 2'b00);
		wait_ovf();
		wait_ovf();
		check("period div4", 16'(n + 1), 16'h0400);
		check("flag", 16'(flag), 16'h0001);
		@(negedge sys_clk);
		check("ovf one cycle", 16'(ovf), 16'h0000);
		repeat (6) @(negedge sys_clk);
		cpu.op(1, 4'h0, 2'b00);
		check("count after wrap", 16'(count_value), 16'h0002);
		cpu.op(2, 4'h0, 2'b00);
		check("skip hit", 16'({skip_hit, flag}), 16'h0002);
		cpu.op(2, 4'h0, 2'b00);
		check("skip miss", 16'(skip_hit), 16'h0000);
	endtask
	task automatic s_div32_halt();
		cpu.op(3, MODE_PORT_SEL, 2'b10);
		wait_ovf();
		wait_ovf();
		check("period div32", 16'(n + 1), 16'h2000);
		cpu.op(4, 4'h0, 2'b00);
		check("halt refused", 16'(halt_active), 16'h0000);
		cpu.op(2, 4'h0, 2'b00);
		cpu.op(4, 4'h0, 2'b00);
		check("halt entered", 16'(halt_active), 16'h0001);
		wait_ovf();
		@(negedge sys_clk);
		check("halt woken", 16'({halt_active, flag}), 16'h0001);
		cpu.op(0, 4'h0, 2'b00);
		cpu.op(1, 4'h0, 2'b00);
		check("start clears", 16'({count_value, flag}), 16'h0000);
	endtask
	task automatic s_event();
		cpu.op(3, MODE_PORT_SEL, 2'b01);
		cpu.op(0, 4'h0, 2'b00);
		repeat (10) begin
			repeat (8) @(negedge sys_clk);
			event_input = ~event_input;
		end
		repeat (8) @(negedge sys_clk);
		cpu.op(1, 4'h0, 2'b00);
		check("event count", 16'(count_value), 16'h0005);
	endtask
	// pin edge timed so its pulse lands on the read cycle
	task automatic s_read_hold();
		@(negedge sys_clk);
		event_input = 1'b1;
		repeat (2) @(negedge sys_clk);
		cpu.op(1, 4'h0, 2'b00);
		check("read during pulse", 16'(count_value), 16'h0005);
		cpu.op(1, 4'h0, 2'b00);
		check("held pulse applied", 16'(count_value), 16'h0006);
		event_input = 1'b0;
	endtask
	task automatic s_stop_reset();
		cpu.other_flag(1'b1);
		cpu.op(5, 4'h0, 2'b00);
		check("stop refused", 16'(stop_active), 16'h0000);
		cpu.other_flag(1'b0);
		cpu.op(4, 4'h0, 2'b00);
		check("halt entered", 16'(halt_active), 16'h0001);
		cpu.other_flag(1'b1);
		@(negedge sys_clk);
		check("halt woken by other flag", 16'(halt_active), 16'h0000);
		cpu.other_flag(1'b0);
		cpu.op(5, 4'h0, 2'b00);
		check("stop entered", 16'(stop_active), 16'h0001);
		@(negedge sys_clk);
		rstn = 1'b0;
		repeat (2) @(negedge sys_clk);
		check("reset state", 16'({stop_active, halt_active, flag, src}), 16'(SRC_RESET));
		rstn = 1'b1;
		repeat (3) @(negedge sys_clk);
		cpu.op(1, 4'h0, 2'b00);
		check("count after reset", 16'(count_value), 16'(COUNT_RESET));
	endtask
	initial begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (3) @(negedge sys_clk);
		s_div4();
		s_div32_halt();
		s_event();
		s_read_hold();
		s_stop_reset();
		report_and_stop();
	end
endmodule
`default_nettype wire

//--- test/tec_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module tec_cpu_model (
	input  wire logic       sys_clk,
	output logic            timer_start,
	output logic            read_count,
	output logic            skip_test,
	output logic            port_out_strobe,
	output logic [3:0]      port_sel,
	output logic [3:0]      port_data,
	output logic            halt_request,
	output logic            stop_request,
	output logic            other_request_flag
);
	initial begin
		{timer_start, read_count, skip_test, port_out_strobe} = 4'h0;
		{halt_request, stop_request, other_request_flag} = 3'h0;
		{port_sel, port_data} = 8'h00;
	end
	// one instruction every two cycles, strobe high for one; bus inverted after so a stale value is never held unchanged
	task automatic op(input int k, input logic [3:0] sel, input logic [1:0] code);
		@(negedge sys_clk);
		port_sel = sel;
		port_data = {1'b0, code, 1'b0};
		case (k)
			0: timer_start = 1'b1;
			1: read_count = 1'b1;
			2: skip_test = 1'b1;
			3: port_out_strobe = 1'b1;
			5: stop_request = 1'b1;
			default: halt_request = 1'b1;
		endcase
		@(negedge sys_clk);
		{timer_start, read_count, skip_test, port_out_strobe, halt_request, stop_request} = 6'h00;
		{port_sel, port_data} = ~{port_sel, port_data};
	endtask
	// other request sources are one level, held until changed
	task automatic other_flag(input logic v);
		@(negedge sys_clk);
		other_request_flag = v;
	endtask
endmodule
`default_nettype wire
